// *** smr_regs.svh ***
// Purpose: constants for the mode-register bank (addresses, fields, resets)
// Assumes: 8-bit mode address and 8-bit operand
// Notes:   included by the bank module, the checker and the testbench
`ifndef SMR_REGS_SVH
`define SMR_REGS_SVH
`define SMR_MA_FEATURE    8'h01
`define SMR_MA_LATENCY    8'h02
`define SMR_MA_DRIVE      8'h03
`define SMR_MA_THERMAL    8'h04
`define SMR_BL4           3'h2
`define SMR_BL8           3'h3
`define SMR_BL16          3'h4
`define SMR_FEATURE_RST   8'h22
`define SMR_LAT_RST       4'h1
`define SMR_DRV_RST       4'h2
`define SMR_RATE_RST      3'h3
`define SMR_UPD_BIT       7
`endif

// *** smr_pkg.sv ***
// Purpose: types for the mode-register bank
// Assumes: smr_regs.svh holds the numbers
// Notes:   packed structs carry grouped signals
package smr_pkg;
  typedef struct packed {
    logic       valid;
    logic       isRead;
    logic [7:0] addr;
    logic [7:0] data;
  } smr_cmd_s;
  typedef struct packed {
    logic [2:0] burstLen;
    logic       burstOrderType;
    logic       wrapSelect;
  } smr_burst_s;
endpackage

// *** smr_mode_bank.sv ***
// Purpose: mode registers for latency, drive, thermal status, burst order
// Assumes: controller keeps burst/no-wrap legality on its side
// Notes:   one clock; temperature code comes from an on-die sensor pin
//
// Functional notes
// - BL16 sequential wrap starts at even column C[3:1], steps up, wraps F to 0.
// - Burst position uses C[1:0], C[2:0], C[3:0] for BL4, BL8, BL16.
// - Column bit zero is absent on the bus and forced zero.
// - Latency register at 02h write-only; low nibble selects read/write latency pair.
// - Drive register at 03h write-only; low nibble selects output impedance.
// - Thermal register 04h read-only: rate in bits 2:0, flag bit 7.
// - Rate 000b below low limit, 111b above high limit, 100b reserved.
// - Rate 001b 4x, 010b 2x, 011b 1x, 101b/110b quarter interval.
// - Above 85 C the rate code bit 2 reads one.
// - Update flag sets whenever the rate code changed since the last read.
// - Reading the thermal register clears the update flag.
// - Update flag is zero after power-up.
// - Feature register at 01h holds burst length, order type and wrap select.
`timescale 1ns/1ps
`default_nettype none
`include "smr_regs.svh"
module smr_mode_bank
  import smr_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // Mode-register commands on the command/address bus
  input  wire smr_cmd_s   cmdIn,
  output logic            readValid,
  output logic [7:0]      readData,
  // Sensor code from the on-die thermometer
  input  wire logic [2:0] sensorRate,
  input  wire logic       over85,
  // Burst start and sequence
  input  wire logic       burstStart,
  input  wire logic [3:0] startColumn,
  output logic [3:0]      burstColumn,
  output logic            burstActive,
  // Decoded settings
  output logic [3:0]      read_latency_cycles,
  output logic [2:0]      write_latency_cycles,
  output logic [3:0]      drive_strength_sel,
  output smr_burst_s      burstCfg
);

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  wire logic wrFeature = cmdIn.valid & ~cmdIn.isRead & (cmdIn.addr == `SMR_MA_FEATURE);
  wire logic wrLatency = cmdIn.valid & ~cmdIn.isRead & (cmdIn.addr == `SMR_MA_LATENCY);
  wire logic wrDrive   = cmdIn.valid & ~cmdIn.isRead & (cmdIn.addr == `SMR_MA_DRIVE);
  wire logic rdThermal = cmdIn.valid & cmdIn.isRead & (cmdIn.addr == `SMR_MA_THERMAL);

  function automatic logic latOk(input logic [3:0] c);
    latOk = (c >= 4'h1) && (c <= 4'h6);
  endfunction
  function automatic logic drvOk(input logic [3:0] c);
    drvOk = (c != 4'h0) && (c != 4'h5) && (c <= 4'h7);
  endfunction

  // ---------------------------------------------------------------
  // Write-only settings
  // ---------------------------------------------------------------
  logic [7:0] feature_q;
  logic [3:0] latency_q;
  logic [3:0] drive_q;

  wire logic latTake = wrLatency & latOk(cmdIn.data[3:0]);
  wire logic drvTake = wrDrive & drvOk(cmdIn.data[3:0]);

  // Reserved latency and drive codes are ignored so the last legal setting stays in force
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      feature_q <= `SMR_FEATURE_RST;
    end else if (wrFeature) begin
      feature_q <= cmdIn.data;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      latency_q <= `SMR_LAT_RST;
    end else if (latTake) begin
      latency_q <= cmdIn.data[3:0];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      drive_q <= `SMR_DRV_RST;
    end else if (drvTake) begin
      drive_q <= cmdIn.data[3:0];
    end
  end

  // Latency pair decode; only legal codes ever reach latency_q
  function automatic logic [3:0] rlOf(input logic [3:0] c);
    case (c)
      4'h1:    rlOf = 4'h3;
      4'h2:    rlOf = 4'h4;
      4'h3:    rlOf = 4'h5;
      4'h4:    rlOf = 4'h6;
      4'h5:    rlOf = 4'h7;
      4'h6:    rlOf = 4'h8;
      default: rlOf = 4'h3;
    endcase
  endfunction

  function automatic logic [2:0] wlOf(input logic [3:0] c);
    case (c)
      4'h1:    wlOf = 3'h1;
      4'h2:    wlOf = 3'h2;
      4'h3:    wlOf = 3'h2;
      4'h4:    wlOf = 3'h3;
      4'h5:    wlOf = 3'h4;
      4'h6:    wlOf = 3'h4;
      default: wlOf = 3'h1;
    endcase
  endfunction

  wire logic [3:0] rlNext  = rlOf(latency_q);
  wire logic [2:0] wlNext  = wlOf(latency_q);
  wire smr_burst_s cfgNext = {feature_q[2:0], feature_q[3], feature_q[4]};

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      read_latency_cycles  <= 4'h3;
      write_latency_cycles <= 3'h1;
    end else begin
      read_latency_cycles  <= rlNext;
      write_latency_cycles <= wlNext;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      drive_strength_sel <= `SMR_DRV_RST;
      burstCfg           <= '0;
    end else begin
      drive_strength_sel <= drive_q;
      burstCfg           <= cfgNext;
    end
  end

  // ---------------------------------------------------------------
  // Thermal status
  // ---------------------------------------------------------------
  logic [2:0] senS1_q, senS2_q;
  logic [2:0] senS3_q;
  logic [2:0] senWord_q;
  logic       hotS1_q, hotS2_q;
  logic [2:0] rate_q;
  logic       upd_q;

  // Skewed bits of the sensor word are held off until two samples agree
  wire logic wordSettled = (senS2_q == senS3_q);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      senS1_q   <= `SMR_RATE_RST;
      senS2_q   <= `SMR_RATE_RST;
      senS3_q   <= `SMR_RATE_RST;
      senWord_q <= `SMR_RATE_RST;
      hotS1_q   <= 1'b0;
      hotS2_q   <= 1'b0;
    end else begin
      senS1_q <= sensorRate;
      senS2_q <= senS1_q;
      senS3_q <= senS2_q;
      if (wordSettled) senWord_q <= senS3_q;
      hotS1_q <= over85;
      hotS2_q <= hotS1_q;
    end
  end

  // Hot forces bit 2; reserved 100b is remapped to quarter-rate derated
  wire logic [2:0] rawRate = hotS2_q ? (senWord_q | 3'h4) : senWord_q;
  wire logic [2:0] rateD   = (rawRate == 3'h4) ? 3'h6 : rawRate;
  wire logic       changed = (rateD != rate_q);

  // Change in the read cycle wins over the clear
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rate_q <= `SMR_RATE_RST;
      upd_q  <= 1'b0;
    end else begin
      rate_q <= rateD;
      if (changed) upd_q <= 1'b1;
      else if (rdThermal) upd_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  // Write-only and unmapped addresses read as zero
  wire logic [7:0] rdMux = rdThermal ? {upd_q, 4'h0, rate_q} : 8'h00;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      readValid <= 1'b0;
      readData  <= 8'h00;
    end else begin
      readValid <= cmdIn.valid & cmdIn.isRead;
      readData  <= rdMux;
    end
  end

  // ---------------------------------------------------------------
  // Burst state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    BURST_IDLE = 2'b01,
    BURST_RUN  = 2'b10
  } smr_burst_state_e;

  smr_burst_state_e state_q;
  smr_burst_state_e state_d;
  logic [3:0]       pos_q;
  logic [3:0]       base_q;
  logic [3:0]       cnt_q;

  // Index of the last beat; reserved lengths fall back to four beats
  function automatic logic [3:0] lastIdx(input logic [2:0] len);
    case (len)
      `SMR_BL16: lastIdx = 4'hf;
      `SMR_BL8:  lastIdx = 4'h7;
      default:   lastIdx = 4'h3;
    endcase
  endfunction

  wire logic       actRun    = (state_q == BURST_RUN);
  wire logic [3:0] beats     = lastIdx(feature_q[2:0]);
  wire logic       lastBeat  = actRun && (cnt_q == beats);
  wire logic       startTake = (state_q == BURST_IDLE) && burstStart;

  // A start request during a burst is dropped, not queued
  always_comb begin
    state_d = state_q;
    case (state_q)
      BURST_IDLE: begin
        if (burstStart) state_d = BURST_RUN;
      end
      BURST_RUN: begin
        if (lastBeat) state_d = BURST_IDLE;
      end
      default: begin
        state_d = BURST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= BURST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------
  // Burst column sequencer
  // ---------------------------------------------------------------
  wire logic [3:0] wrapMask = lastIdx(feature_q[2:0]);
  wire logic [3:0] evenStart = {startColumn[3:1], 1'b0};
  wire logic       noWrap  = feature_q[4];
  wire logic       interl  = feature_q[3];
  wire logic [3:0] step = cnt_q + 4'h1;
  // Sequential wraps within the burst window; interleave XORs beat index
  wire logic [3:0] seqNext = (base_q & ~wrapMask) | ((base_q + step) & wrapMask);
  wire logic [3:0] intNext = (base_q & ~wrapMask) | ((base_q ^ step) & wrapMask);
  wire logic [3:0] linNext = base_q + step;
  wire logic [3:0] posNext = noWrap ? linNext : (interl ? intNext : seqNext);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pos_q  <= 4'h0;
      base_q <= 4'h0;
      cnt_q  <= 4'h0;
    end else if (startTake) begin
      pos_q  <= evenStart;
      base_q <= evenStart;
      cnt_q  <= 4'h0;
    end else if (actRun && !lastBeat) begin
      pos_q <= posNext;
      cnt_q <= step;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      burstColumn <= 4'h0;
      burstActive <= 1'b0;
    end else begin
      burstColumn <= pos_q;
      burstActive <= actRun;
    end
  end

endmodule // smr_mode_bank
`default_nettype wire

// *** smr_checker.sv ***
// Purpose: port assertions for smr_mode_bank
// Assumes: no burst starts while one runs
// Notes: bound to the bank below
`timescale 1ns/1ps
`default_nettype none
`include "smr_regs.svh"
module smr_checker
  import smr_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire smr_cmd_s   cmdIn,
  input wire logic       readValid,
  input wire logic [7:0] readData,
  input wire logic       over85,
  input wire logic [3:0] burstColumn,
  input wire logic       burstActive,
  input wire logic [3:0] read_latency_cycles,
  input wire logic [3:0] drive_strength_sel,
  input wire smr_burst_s burstCfg
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire rdReq = cmdIn.valid && cmdIn.isRead;
  wire wrLat = cmdIn.valid && !cmdIn.isRead && cmdIn.addr == `SMR_MA_LATENCY;
  wire wrDrv = cmdIn.valid && !cmdIn.isRead && cmdIn.addr == `SMR_MA_DRIVE;
  read_answer_a: assert property (rdReq |=> readValid)
    else $error("read not answered");
  write_only_a: assert property (rdReq && cmdIn.addr != `SMR_MA_THERMAL |=> readData == 8'h00)
    else $error("non-status read not zero");
  status_rsvd_a: assert property (readValid |-> readData[6:3] == 4'h0)
    else $error("reserved status bits set");
  latency_set_a: assert property (wrLat && cmdIn.data[3:0] inside {[1:6]}
    |=> ##1 read_latency_cycles == $past(cmdIn.data[3:0], 2) + 4'h2)
    else $error("latency decode wrong");
  lat_refuse_a: assert property (wrLat && !(cmdIn.data[3:0] inside {[1:6]}) |=> ##1 $stable(read_latency_cycles))
    else $error("reserved latency taken");
  drive_set_a: assert property (wrDrv && cmdIn.data[3:0] inside {1, 2, 3, 4, 6, 7}
    |=> ##1 drive_strength_sel == $past(cmdIn.data[3:0], 2))
    else $error("drive decode wrong");
  hot_bit_a: assert property (rdReq && cmdIn.addr == `SMR_MA_THERMAL && over85 && $past(over85, 3)
    && $past(over85, 2) && $past(over85) && $past(resetn, 4) |=> readData[2])
    else $error("hot bit not forced");
  even_start_a: assert property ($rose(burstActive) |-> burstColumn[0] == 1'b0)
    else $error("odd burst start");
  wrap16_a: assert property (burstActive && $past(burstActive) && burstCfg.burstLen == `SMR_BL16
    && !burstCfg.burstOrderType |-> burstColumn == $past(burstColumn) + 4'h1)
    else $error("16-beat step wrong");
  bl4_stay_a: assert property (burstActive && $past(burstActive) && burstCfg.burstLen == `SMR_BL4
    && !burstCfg.wrapSelect |-> burstColumn[3:2] == $past(burstColumn[3:2]))
    else $error("4-beat left its group");
  cover property (readValid && readData[7]);
  cover property ($rose(burstActive) && burstCfg.burstLen == `SMR_BL16);
  cover property (wrLat);
endmodule // smr_checker
bind smr_mode_bank smr_checker chk_u (.clk_sys(clk_sys), .resetn(resetn), .cmdIn(cmdIn),
  .readValid(readValid), .readData(readData), .over85(over85), .burstColumn(burstColumn),
  .burstActive(burstActive), .read_latency_cycles(read_latency_cycles),
  .drive_strength_sel(drive_strength_sel), .burstCfg(burstCfg));
`default_nettype wire

// *** smr_host_model.sv ***
// Purpose: controller issuing mode-register commands
// Assumes: one command in flight
// Notes: caller picks legal burst settings
`timescale 1ns/1ps
`default_nettype none
module smr_host_model
  import smr_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       readValid,
  input  wire logic [7:0] readData,
  output var smr_cmd_s    cmdIn
);
  initial cmdIn = '0;
  // Released fields inverted so stale values never pass
  task automatic issue(input logic rd, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    cmdIn <= '{1'b1, rd, a, d};
    @(posedge clk_sys);
    cmdIn <= '{1'b0, ~rd, ~a, ~d};
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    issue(1'b0, a, d);
  endtask
  // Caller reacts to 000b/111b and derating itself
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    issue(1'b1, a, 8'h00);
    for (n = 0; n < 4 && readValid !== 1'b1; n++) @(negedge clk_sys);
    d = readData;
  endtask
endmodule // smr_host_model
`default_nettype wire

// *** smr_testbench.sv ***
// Purpose: self-checking bench for smr_mode_bank
// Assumes: host model drives cmdIn
// Notes: no random stimulus
`timescale 1ns/1ps
`default_nettype none
`include "smr_regs.svh"
module testbench
  import smr_pkg::*;
;
  logic clk_sys = 1'b0, resetn = 1'b0, over85 = 1'b0, burstStart = 1'b0, readValid, burstActive;
  logic [2:0] sensorRate = 3'h3, wlOut;
  logic [3:0] startColumn = 4'h0, burstColumn, rlOut, dsOut;
  logic [7:0] readData, d;
  smr_cmd_s   cmdIn;
  smr_burst_s burstCfg;
  int failures = 0, checks = 0;
  always #2 clk_sys = ~clk_sys;
  smr_host_model host_u (.clk_sys(clk_sys), .readValid(readValid), .readData(readData), .cmdIn(cmdIn));
  smr_mode_bank dut_u (.clk_sys(clk_sys), .resetn(resetn), .cmdIn(cmdIn), .readValid(readValid),
    .readData(readData), .sensorRate(sensorRate), .over85(over85), .burstStart(burstStart),
    .startColumn(startColumn), .burstColumn(burstColumn), .burstActive(burstActive),
    .read_latency_cycles(rlOut), .write_latency_cycles(wlOut), .drive_strength_sel(dsOut), .burstCfg(burstCfg));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_settings();
    logic [3:0] rl = 4'h3, ds = 4'h2;
    logic [2:0] wl = 3'h1;
    repeat (2) @(negedge clk_sys);
    chk({3'h0, burstCfg}, {3'h0, `SMR_BL4, 2'b00});
    host_u.rd(`SMR_MA_THERMAL, d);
    chk(d, 8'h03);
    for (int c = 0; c < 8; c++) begin
      host_u.wr(`SMR_MA_LATENCY, {4'hf, 4'(c)});
      host_u.wr(`SMR_MA_DRIVE, {4'ha, 4'(c)});
      repeat (3) @(negedge clk_sys);
      if (c inside {[1:6]}) {rl, wl} = {4'(c + 2), 3'(c - c / 3)};
      if (c inside {1, 2, 3, 4, 6, 7}) ds = 4'(c);
      chk({rlOut, 1'b0, wlOut}, {rl, 1'b0, wl});
      chk({4'h0, dsOut}, {4'h0, ds});
    end
    host_u.rd(`SMR_MA_LATENCY, d);
    chk(d, 8'h00);
    $display("test settings done");
  endtask
  task automatic t_thermal();
    for (int c = 0; c < 10; c++) begin
      @(posedge clk_sys);
      sensorRate <= (c > 7) ? 3'h3 : 3'(c);
      over85 <= (c == 8);
      repeat (6) @(negedge clk_sys);
      host_u.rd(`SMR_MA_THERMAL, d);
      if (c < 8) chk(d, {1'b1, 4'h0, (c == 4) ? 3'h6 : 3'(c)});
      else chk(d, (c == 8) ? 8'h07 : 8'h83);
    end
    host_u.rd(`SMR_MA_THERMAL, d);
    chk(d, 8'h03);
    $display("test thermal done");
  endtask
  task automatic t_burst(input logic [7:0] feat, input logic [3:0] s, input int bl, input logic intl);
    int n;
    logic [3:0] m, b, e;
    host_u.wr(`SMR_MA_FEATURE, feat);
    repeat (3) @(negedge clk_sys);
    chk({3'h0, burstCfg}, {3'h0, feat[2:0], feat[3], feat[4]});
    m = 4'(bl - 1);
    b = s & 4'he;
    @(posedge clk_sys);
    {burstStart, startColumn} <= {1'b1, s};
    @(posedge clk_sys);
    {burstStart, startColumn} <= {1'b0, ~s};
    for (n = 0; n < 6 && burstActive !== 1'b1; n++) @(negedge clk_sys);
    for (n = 0; n < bl; n++) begin
      e = intl ? (b ^ 4'(n)) : feat[4] ? (b + 4'(n)) : ((b & ~m) | ((b + 4'(n)) & m));
      chk({4'h0, burstColumn}, {4'h0, e});
      @(negedge clk_sys);
    end
    chk({7'h0, burstActive}, 8'h00);
    $display("test burst %0d done", bl);
  endtask
  initial begin
    #100000;
    failures++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    t_settings();
    t_thermal();
    t_burst(8'h24, 4'h7, 16, 1'b0);
    t_burst(8'h2b, 4'h3, 8, 1'b1);
    t_burst(8'h22, 4'hb, 4, 1'b0);
    t_burst(8'h32, 4'h6, 4, 1'b0);
    end_sim();
  end
endmodule // testbench
`default_nettype wire
